/* hw/iie_pkg.sv */
// constants for the isolated input event logic
package iie_pkg;
  localparam int NCH = 8;

  // register bus byte addresses
  localparam logic [7:0] ADDR_H2C = 8'h00;
  localparam logic [7:0] ADDR_C2H = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL = 8'h10;

  // mailbox word layout: command code, 16-bit parameter / result
  localparam int CODE_LSB = 0;
  localparam int PARAM_LSB = 8;

  // command codes
  localparam logic [7:0] CMD_FILT_EN = 8'h20;
  localparam logic [7:0] CMD_PAT_EN = 8'h21;
  localparam logic [7:0] CMD_PAT_VAL = 8'h22;
  localparam logic [7:0] CMD_RISE_EN = 8'h23;
  localparam logic [7:0] CMD_FALL_EN = 8'h24;
  localparam logic [7:0] CMD_CNT_EN = 8'h28;
  localparam logic [7:0] CMD_CNT_RST = 8'h29;
  localparam logic [7:0] CMD_OVF_IE = 8'h2A;
  localparam logic [7:0] CMD_MATCH_IE = 8'h2B;
  localparam logic [7:0] CMD_CNT_EDGE = 8'h2C;
  localparam logic [7:0] CMD_CNT_READ = 8'h2F;
  localparam logic [4:0] CMD_HIGH_GRP = 5'h06;
  localparam logic [4:0] CMD_LOW_GRP = 5'h07;
  localparam logic [4:0] CMD_RSTV_GRP = 5'h08;
  localparam logic [4:0] CMD_MATV_GRP = 5'h09;
  localparam logic [7:0] CMD_RD_INT = 8'h60;
  localparam logic [7:0] CMD_RD_EDGE = 8'h61;
  localparam logic [7:0] CMD_RD_CNTF = 8'h62;

  // interrupt status bit positions
  localparam int IRQ_PAT = 0;
  localparam int IRQ_COS = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_MATCH = 3;
  localparam int NIRQ = 4;

  // filter step timing
  localparam int FILTER_STEP_MS = 5;
  localparam int CLK_HZ = 200_000_000;
  localparam int FILTER_STEP_CYCLES = FILTER_STEP_MS * (CLK_HZ / 1000);

  // reset values and limits
  localparam logic [15:0] STEP_MIN = 16'h0002;
  localparam logic [15:0] STEP_RESET = 16'h0002;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [NIRQ-1:0] IRQ_MASK_RESET = 4'h0;
endpackage : iie_pkg

/* hw/iie_input_events.sv */
// eight-channel isolated input filter, pattern, edge and counter logic
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module iie_input_events #(
  parameter int unsigned STEP_CYCLES = iie_pkg::FILTER_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] isolated_input,
  output logic [31:0] rdata,
  output logic irq
);
  localparam int N = iie_pkg::NCH;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] in_s1_reg, in_s2_reg;
  logic [19:0] tick_cnt_reg;
  logic [7:0] level_reg, level_next;
  logic [16:0] deb_reg [N];
  logic [16:0] deb_next [N];
  logic [15:0] high_n_reg [N];
  logic [15:0] low_n_reg [N];
  logic [15:0] rstv_reg [N];
  logic [15:0] matv_reg [N];
  logic [15:0] cnt_reg [N];
  logic [15:0] cnt_next [N];
  logic [7:0] filt_en_reg, pat_en_reg, pat_val_reg, rise_en_reg, fall_en_reg;
  logic [7:0] cnt_en_reg, ovf_ie_reg, mat_ie_reg, cnt_fall_reg;
  logic [7:0] rise_flag_reg, fall_flag_reg, ovf_flag_reg, mat_flag_reg;
  logic pat_now_reg;
  logic [iie_pkg::NIRQ-1:0] status_reg, status_next, mask_reg;
  logic [31:0] c2h_reg, rdata_reg;
  logic irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire tick = tick_cnt_reg == 20'(STEP_CYCLES - 1);
  wire h2c_wr = wr_en && addr == iie_pkg::ADDR_H2C;
  wire [7:0] code = wdata[iie_pkg::CODE_LSB +: 8];
  wire [15:0] prm = wdata[iie_pkg::PARAM_LSB +: 16];
  wire [2:0] ch = code[2:0];
  wire [2:0] prm_ch = prm[2:0];
  wire cmd_high = h2c_wr && code[7:3] == iie_pkg::CMD_HIGH_GRP;
  wire cmd_low = h2c_wr && code[7:3] == iie_pkg::CMD_LOW_GRP;
  wire cmd_rstv = h2c_wr && code[7:3] == iie_pkg::CMD_RSTV_GRP;
  wire cmd_matv = h2c_wr && code[7:3] == iie_pkg::CMD_MATV_GRP;
  wire cmd_rst = h2c_wr && code == iie_pkg::CMD_CNT_RST;
  wire clr_edge = h2c_wr && code == iie_pkg::CMD_RD_EDGE;
  wire clr_cntf = h2c_wr && code == iie_pkg::CMD_RD_CNTF;
  wire stat_wr = wr_en && addr == iie_pkg::ADDR_STATUS;
  wire [7:0] rst_hit = cmd_rst ? prm[7:0] : 8'h00;
  wire [15:0] sel_cnt = cnt_reg[prm_ch];

  ////////////////////////////////////////////////////////////////////////////
  // filter, edges and counters
  logic [7:0] deb_hit, rise_w, fall_w, cev, ovf_ev, mat_ev;
  logic [16:0] lim [N];

  always_comb begin
    for (int i = 0; i < N; i++) begin
      // waiting for low when high; clamp below the legal minimum of two
      lim[i] = level_reg[i] ?
        ((low_n_reg[i] < iie_pkg::STEP_MIN) ? {1'b0, iie_pkg::STEP_MIN}
                                            : {1'b0, low_n_reg[i]}) :
        ((high_n_reg[i] < iie_pkg::STEP_MIN) ? {1'b0, iie_pkg::STEP_MIN}
                                             : {1'b0, high_n_reg[i]});
      // one extra step, plus one to cover the partial first step
      lim[i] = 17'(lim[i] + 17'h0_0002);
      deb_hit[i] = 1'b0;
      level_next[i] = level_reg[i];
      deb_next[i] = 17'h0_0000;
      if (!filt_en_reg[i]) begin
        level_next[i] = in_s2_reg[i];
      end else if (in_s2_reg[i] != level_reg[i]) begin
        deb_next[i] = deb_reg[i];
        if (tick) begin
          if (17'(deb_reg[i] + 17'h0_0001) >= lim[i]) begin
            deb_hit[i] = 1'b1;
            level_next[i] = in_s2_reg[i];
            deb_next[i] = 17'h0_0000;
          end else begin
            deb_next[i] = 17'(deb_reg[i] + 17'h0_0001);
          end
        end
      end
    end
  end

  // edges taken from the level each cycle, far faster than 1 ms phases
  assign rise_w = level_next & ~level_reg;
  assign fall_w = ~level_next & level_reg;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      cev[i] = cnt_en_reg[i] && (cnt_fall_reg[i] ? fall_w[i] : rise_w[i]);
      ovf_ev[i] = cev[i] && !rst_hit[i] && cnt_reg[i] == iie_pkg::CNT_MAX;
      mat_ev[i] = cev[i] && !rst_hit[i] &&
                  16'(cnt_reg[i] + 16'h0001) == matv_reg[i];
      if (rst_hit[i]) begin
        cnt_next[i] = rstv_reg[i];
      end else if (cev[i]) begin
        cnt_next[i] = 16'(cnt_reg[i] + 16'h0001);
      end else begin
        cnt_next[i] = cnt_reg[i];
      end
    end
  end

  wire [7:0] rise_set = rise_w & rise_en_reg;
  wire [7:0] fall_set = fall_w & fall_en_reg;
  wire cos_ev = |rise_set || |fall_set;
  wire pat_now = pat_en_reg != 8'h00 &&
                 ((level_next ^ pat_val_reg) & pat_en_reg) == 8'h00;
  wire pat_ev = pat_now && !pat_now_reg;
  wire ovf_irq = |(ovf_ev & ovf_ie_reg);
  wire mat_irq = |(mat_ev & mat_ie_reg);
  wire [iie_pkg::NIRQ-1:0] irq_ev = {mat_irq, ovf_irq, cos_ev, pat_ev};
  wire [iie_pkg::NIRQ-1:0] stat_clr =
    stat_wr ? wdata[iie_pkg::NIRQ-1:0] : 4'h0;
  // set beats clear when both land in one cycle
  assign status_next = (status_reg & ~stat_clr) | irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // mailbox result
  logic [15:0] result;
  always_comb begin
    unique case (code)
      iie_pkg::CMD_CNT_READ: result = sel_cnt;
      iie_pkg::CMD_RD_INT: result = {12'h000, status_reg};
      iie_pkg::CMD_RD_EDGE: result = {fall_flag_reg, rise_flag_reg};
      iie_pkg::CMD_RD_CNTF: result = {mat_flag_reg, ovf_flag_reg};
      default: result = 16'h0000;
    endcase
  end

  wire [31:0] c2h_next = h2c_wr ? {8'h00, result, code} : c2h_reg;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr)
      iie_pkg::ADDR_C2H: rd_mux = c2h_reg;
      iie_pkg::ADDR_STATUS: rd_mux = {28'h000_0000, status_reg};
      iie_pkg::ADDR_MASK: rd_mux = {28'h000_0000, mask_reg};
      iie_pkg::ADDR_LEVEL: rd_mux = {24'h00_0000, level_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_s1_reg <= 8'h00;
      in_s2_reg <= 8'h00;
      tick_cnt_reg <= 20'h0_0000;
      level_reg <= 8'h00;
      pat_now_reg <= 1'b0;
      status_reg <= '0;
      c2h_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      in_s1_reg <= isolated_input;
      in_s2_reg <= in_s1_reg;
      tick_cnt_reg <= tick ? 20'h0_0000 : 20'(tick_cnt_reg + 20'h0_0001);
      level_reg <= level_next;
      pat_now_reg <= pat_now;
      status_reg <= status_next;
      c2h_reg <= c2h_next;
      rdata_reg <= rd_en ? rd_mux : 32'h0000_0000;
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        deb_reg[i] <= 17'h0_0000;
        cnt_reg[i] <= iie_pkg::CNT_RESET;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        deb_reg[i] <= deb_next[i];
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  // per-channel values written by the 30..4F command groups
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        high_n_reg[i] <= iie_pkg::STEP_RESET;
        low_n_reg[i] <= iie_pkg::STEP_RESET;
        rstv_reg[i] <= iie_pkg::CNT_RESET;
        matv_reg[i] <= iie_pkg::CNT_MAX;
      end
    end else begin
      if (cmd_high) high_n_reg[ch] <= prm;
      if (cmd_low) low_n_reg[ch] <= prm;
      if (cmd_rstv) rstv_reg[ch] <= prm;
      if (cmd_matv) matv_reg[ch] <= prm;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_en_reg <= iie_pkg::MASK_RESET;
      pat_en_reg <= iie_pkg::MASK_RESET;
      pat_val_reg <= iie_pkg::MASK_RESET;
      rise_en_reg <= iie_pkg::MASK_RESET;
      fall_en_reg <= iie_pkg::MASK_RESET;
      cnt_en_reg <= iie_pkg::MASK_RESET;
      ovf_ie_reg <= iie_pkg::MASK_RESET;
      mat_ie_reg <= iie_pkg::MASK_RESET;
      cnt_fall_reg <= iie_pkg::MASK_RESET;
      mask_reg <= iie_pkg::IRQ_MASK_RESET;
    end else begin
      if (h2c_wr) begin
        unique case (code)
          iie_pkg::CMD_FILT_EN: filt_en_reg <= prm[7:0];
          iie_pkg::CMD_PAT_EN: pat_en_reg <= prm[7:0];
          iie_pkg::CMD_PAT_VAL: pat_val_reg <= prm[7:0];
          iie_pkg::CMD_RISE_EN: rise_en_reg <= prm[7:0];
          iie_pkg::CMD_FALL_EN: fall_en_reg <= prm[7:0];
          iie_pkg::CMD_CNT_EN: cnt_en_reg <= prm[7:0];
          iie_pkg::CMD_OVF_IE: ovf_ie_reg <= prm[7:0];
          iie_pkg::CMD_MATCH_IE: mat_ie_reg <= prm[7:0];
          iie_pkg::CMD_CNT_EDGE: cnt_fall_reg <= prm[7:0];
          default: ;
        endcase
      end
      if (wr_en && addr == iie_pkg::ADDR_MASK) begin
        mask_reg <= wdata[iie_pkg::NIRQ-1:0];
      end
    end
  end

  // flags clear on the read command that returns them; new events win
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rise_flag_reg <= 8'h00;
      fall_flag_reg <= 8'h00;
      ovf_flag_reg <= 8'h00;
      mat_flag_reg <= 8'h00;
    end else begin
      rise_flag_reg <= (clr_edge ? 8'h00 : rise_flag_reg) | rise_set;
      fall_flag_reg <= (clr_edge ? 8'h00 : fall_flag_reg) | fall_set;
      ovf_flag_reg <= (clr_cntf ? 8'h00 : ovf_flag_reg) | ovf_ev;
      mat_flag_reg <= (clr_cntf ? 8'h00 : mat_flag_reg) | mat_ev;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // channel 2 is the one the bench filters
  property p_filt_hold;
    $past(filt_en_reg[2]) && level_reg[2] != $past(level_reg[2])
      |-> $past(deb_hit[2]);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("level moved early");

  property p_deb_limit;
    deb_hit[2] |-> 17'(deb_reg[2] + 17'h0_0001) == lim[2];
  endproperty
  a_deb_limit: assert property (p_deb_limit) else $error("bad step count");

  property p_pat_irq;
    pat_ev |=> status_reg[iie_pkg::IRQ_PAT];
  endproperty
  a_pat_irq: assert property (p_pat_irq) else $error("pattern lost");

  // channel 1 carries the edge detection traffic
  sequence s_rise1;
    rise_en_reg[1] && rise_w[1];
  endsequence
  property p_cos_irq;
    s_rise1 |=> status_reg[iie_pkg::IRQ_COS] && rise_flag_reg[1];
  endproperty
  a_cos_irq: assert property (p_cos_irq) else $error("change lost");

  property p_edge_en;
    $rose(rise_flag_reg[1]) |-> $past(rise_en_reg[1]);
  endproperty
  a_edge_en: assert property (p_edge_en) else $error("disabled edge set");

  property p_cnt_step;
    cev[0] && !rst_hit[0] |=> cnt_reg[0] == 16'($past(cnt_reg[0]) + 16'h0001);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count missed");

  property p_ovf_irq;
    ovf_ev[0] && ovf_ie_reg[0] |=> status_reg[iie_pkg::IRQ_OVF] ##1 irq_reg
      || !mask_reg[iie_pkg::IRQ_OVF];
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow lost");

  property p_cnt_rst;
    rst_hit[0] |=> cnt_reg[0] == $past(rstv_reg[0]);
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("reset not loaded");

  property p_mat_irq;
    mat_ev[0] && mat_ie_reg[0] |=> status_reg[iie_pkg::IRQ_MATCH];
  endproperty
  a_mat_irq: assert property (p_mat_irq) else $error("match lost");

  property p_rd_edge;
    clr_edge |=> c2h_reg[23:8] == {$past(fall_flag_reg), $past(rise_flag_reg)};
  endproperty
  a_rd_edge: assert property (p_rd_edge) else $error("edge read wrong");

  property p_cnt_read;
    h2c_wr && code == iie_pkg::CMD_CNT_READ |=> c2h_reg[23:8] == $past(sel_cnt);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read wrong");

  sequence s_post;
    h2c_wr;
  endsequence
  sequence s_fetch;
    rd_en && addr == iie_pkg::ADDR_C2H && !h2c_wr;
  endsequence
  property p_mailbox;
    s_post ##1 s_fetch |=> rdata_reg[7:0] == $past(wdata[7:0], 2);
  endproperty
  a_mailbox: assert property (p_mailbox) else $error("no echo");
endmodule : iie_input_events

/* test/iie_pin_source.sv */
// field-side pin source driving the eight isolated inputs
`timescale 1ns/1ps
module iie_pin_source (
  input wire logic clk,
  output logic [7:0] pins
);
  initial pins = 8'h00;

  // changes land just after an edge; the design resynchronises them
  task automatic put(input logic [7:0] v);
    @(posedge clk);
    pins <= v;
  endtask : put
endmodule : iie_pin_source

/* test/tb_isolated_input_event_logic.sv */
// self-checking bench for the isolated input event logic
`timescale 1ns/1ps
module tb_isolated_input_event_logic;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  wire [7:0] pins;
  logic [31:0] rdata;
  logic irq;
  int fails = 0;
  int comparisons = 0;
  int cnt [8] = '{default: 0};
  logic [7:0] cur = 8'h00;
  // upper channels count falling edges so both edge kinds are used
  logic [7:0] fall_edge = 8'hF0;
  logic [31:0] got;

  always #2.5 clk = ~clk;

  iie_input_events #(.STEP_CYCLES(20)) uut (
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .isolated_input(pins),
    .rdata(rdata),
    .irq(irq)
  );

  iie_pin_source src (.clk(clk), .pins(pins));

  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd

  task automatic look(input logic [7:0] a, input string name,
                      input logic [31:0] exp);
    rd(a, got);
    chk(name, exp, got);
  endtask : look

  task automatic cmd(input logic [7:0] code, input logic [15:0] prm);
    wr(iie_pkg::ADDR_H2C, {8'h00, prm, code});
  endtask : cmd

  // result fetched in the cycle straight after the command write
  task automatic ask(input logic [7:0] code, input logic [15:0] prm,
                     input string name, input logic [15:0] exp);
    @(posedge clk);
    addr <= iie_pkg::ADDR_H2C;
    wdata <= {8'h00, prm, code};
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= iie_pkg::ADDR_C2H;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    got = rdata;
    chk(name, {8'h00, exp, code}, got);
  endtask : ask

  // reference counters follow every unfiltered pin change
  task automatic drive(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      if (fall_edge[i] ? (cur[i] & ~v[i]) : (~cur[i] & v[i])) begin
        cnt[i] = (cnt[i] + 1) % 65536;
      end
    end
    cur = v;
    src.put(v);
    repeat (8) @(posedge clk);
  endtask : drive

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hc35a9e76));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    look(iie_pkg::ADDR_STATUS, "status reset", 32'h0000_0000);
    look(iie_pkg::ADDR_MASK, "mask reset", 32'h0000_0000);
    look(iie_pkg::ADDR_LEVEL, "level reset", 32'h0000_0000);
    look(iie_pkg::ADDR_C2H, "result reset", 32'h0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    look(8'h14, "unmapped", 32'h0000_0000);
    @(negedge clk);
    chk("rdata idle", 32'h0000_0000, rdata);
    chk("irq reset", 32'h0000_0000, {31'h0, irq});
    ask(8'h05, 16'h1234, "unknown code", 16'h0000);

    cmd(iie_pkg::CMD_CNT_EN, 16'h00FF);
    cmd(iie_pkg::CMD_CNT_EDGE, {8'h00, fall_edge});
    repeat (24) drive(8'($urandom));
    for (int i = 0; i < 8; i++) begin
      ask(iie_pkg::CMD_CNT_READ, 16'(i), "counter", 16'(cnt[i]));
    end
    look(iie_pkg::ADDR_LEVEL, "level", {24'h0, cur});

    // wrap from the top, then step onto the match value
    drive(8'h00);
    cmd(8'h40, 16'hFFFF);
    cmd(8'h48, 16'h0001);
    cmd(iie_pkg::CMD_CNT_RST, 16'h0001);
    cnt[0] = 65535;
    ask(iie_pkg::CMD_CNT_READ, 16'h0000, "reset load", 16'hFFFF);
    cmd(iie_pkg::CMD_OVF_IE, 16'h0001);
    cmd(iie_pkg::CMD_MATCH_IE, 16'h0001);
    wr(iie_pkg::ADDR_MASK, 32'h0000_000F);
    drive(8'h01);
    look(iie_pkg::ADDR_STATUS, "overflow", 32'h0000_0004);
    drive(8'h00);
    drive(8'h01);
    look(iie_pkg::ADDR_STATUS, "match", 32'h0000_000C);
    ask(iie_pkg::CMD_CNT_READ, 16'h0000, "after wrap", 16'(cnt[0]));
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    wr(iie_pkg::ADDR_MASK, 32'h0000_0000);
    repeat (2) @(negedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    ask(iie_pkg::CMD_RD_CNTF, 16'h0000, "cnt flags", 16'h0101);
    ask(iie_pkg::CMD_RD_CNTF, 16'h0000, "cnt flags clr", 16'h0000);
    ask(iie_pkg::CMD_RD_INT, 16'h0000, "int flags", 16'h000C);
    wr(iie_pkg::ADDR_STATUS, 32'h0000_0004);
    look(iie_pkg::ADDR_STATUS, "w1c one", 32'h0000_0008);
    wr(iie_pkg::ADDR_STATUS, 32'h0000_0008);
    look(iie_pkg::ADDR_STATUS, "w1c all", 32'h0000_0000);
    wr(iie_pkg::ADDR_MASK, 32'h0000_000F);

    // falling edge ignored until its own enable is given
    drive(8'h03);
    cmd(iie_pkg::CMD_RISE_EN, 16'h0002);
    drive(8'h01);
    look(iie_pkg::ADDR_STATUS, "fall unwatched", 32'h0000_0000);
    drive(8'h03);
    look(iie_pkg::ADDR_STATUS, "rise cos", 32'h0000_0002);
    chk("irq cos", 32'h0000_0001, {31'h0, irq});
    ask(iie_pkg::CMD_RD_EDGE, 16'h0000, "rise flags", 16'h0002);
    cmd(iie_pkg::CMD_FALL_EN, 16'h0002);
    drive(8'h01);
    ask(iie_pkg::CMD_RD_EDGE, 16'h0000, "fall flags", 16'h0200);
    wr(iie_pkg::ADDR_STATUS, 32'h0000_0002);

    cmd(iie_pkg::CMD_PAT_VAL, 16'h0005);
    cmd(iie_pkg::CMD_PAT_EN, 16'h000F);
    look(iie_pkg::ADDR_STATUS, "no pattern", 32'h0000_0000);
    drive(8'h05);
    look(iie_pkg::ADDR_STATUS, "pattern", 32'h0000_0001);
    wr(iie_pkg::ADDR_STATUS, 32'h0000_0001);
    // unselected channels move, the match only stays true
    drive(8'hF5);
    look(iie_pkg::ADDR_STATUS, "pattern held", 32'h0000_0000);

    // two steps of 20 cycles; a level needs at least three steps
    cmd(iie_pkg::CMD_FILT_EN, 16'h0004);
    cmd(8'h32, 16'h0002);
    cmd(8'h3A, 16'h0002);
    src.put(8'hF1);
    repeat (50) @(posedge clk);
    src.put(8'hF5);
    repeat (100) @(posedge clk);
    look(iie_pkg::ADDR_LEVEL, "glitch low", 32'h0000_00F5);
    src.put(8'hF1);
    repeat (120) @(posedge clk);
    look(iie_pkg::ADDR_LEVEL, "held low", 32'h0000_00F1);
    src.put(8'hF5);
    repeat (50) @(posedge clk);
    look(iie_pkg::ADDR_LEVEL, "short high", 32'h0000_00F1);
    repeat (100) @(posedge clk);
    look(iie_pkg::ADDR_LEVEL, "held high", 32'h0000_00F5);
    wrap_up();
  end
endmodule : tb_isolated_input_event_logic
